/* File: bench/mii_phy_model.sv */
// PHY partner: free-running link clocks, receive source, transmit capture.
// Assumes the bench fills rx_q and sets col and link_n.
module mii_phy_model (
  // Link clocks
  output logic            tx_clk,
  output logic            rx_clk,
  // Receive side
  output logic [3:0]      rxd,
  output logic            rx_dv,
  output logic            col,
  output logic            link_n,
  // Transmit side
  input  wire logic [3:0] txd,
  input  wire logic       tx_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  logic [3:0] tx_q[$];
  bit         busy;
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    rxd = 4'h0;
    rx_dv = 1'b0;
    col = 1'b0;
    link_n = 1'b0;
  end
  // Clocks of 64 ns, phase unrelated to the core clock
  initial #7 forever #32 tx_clk = ~tx_clk;
  initial #13 forever #32 rx_clk = ~rx_clk;
  // Released data lines toggle every cycle
  always @(negedge rx_clk) if (!busy) rxd <= ~rxd;
  // Capture each unit on the rising clock
  always @(posedge tx_clk) if (tx_active) tx_q.push_back(txd);
  ////////////////////////////////////////
  // Frame out, changing on the falling edge
  task automatic send_rx(input logic serial);
    logic [7:0] b;
    busy = 1'b1;
    while (rx_q.size() > 0) begin
      b = rx_q.pop_front();
      for (int i = 0; i < (serial ? 8 : 2); i++) begin
        @(negedge rx_clk);
        rx_dv <= 1'b1;
        if (serial)
          rxd <= {~rxd[3:1], b[i]};
        else
          rxd <= (i == 0) ? b[3:0] : b[7:4];
      end
    end
    @(negedge rx_clk);
    rx_dv <= 1'b0;
    busy = 1'b0;
  endtask
endmodule

/* File: bench/mii_props.sv */
// Concurrent checks on the MII end's top-level ports.
// Assumes the straps move only while RST is high.
module mii_props (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // MII, link and straps
  input wire logic        TX_CLK,
  input wire logic [3:0]  TXD,
  input wire logic        TRANSMIT_FRAME_ACTIVE,
  input wire logic        RX_DV,
  input wire logic        COL,
  input wire logic        LINK_N,
  input wire logic        SERIAL_SELECT_N,
  input wire logic        DUPLEX_SELECT_N,
  input wire logic        LINK_DOWN
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  wire st_rd = PSEL && PENABLE && PREADY && !PWRITE && PADDR == mii_pkg::STATUS_OFS;
  ////////////////////////////////////////
  a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready one cycle after setup");
  a_unmapped_err: assert property (PREADY && PADDR > 8'h0c |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_tx_stable: assert property ($changed(TXD) && TXD != 4'h0 |-> !TX_CLK)
    else $error("transmit data moved while clock high");
  a_idle_quiet: assert property (!TRANSMIT_FRAME_ACTIVE |-> TXD == 4'h0)
    else $error("data outside frame strobe");
  a_strobe_rise: assert property ($rose(TRANSMIT_FRAME_ACTIVE) |-> !TX_CLK)
    else $error("strobe rose while clock high");
  a_serial_upper: assert property (!SERIAL_SELECT_N |-> TXD[3:1] == 3'h0)
    else $error("upper lines used in serial mode");
  a_fdx_no_abort: assert property (!DUPLEX_SELECT_N && $fell(TRANSMIT_FRAME_ACTIVE) |-> !TX_CLK)
    else $error("frame cut in full duplex");
  a_col_abort: assert property ((DUPLEX_SELECT_N && COL) [*8] |-> !TRANSMIT_FRAME_ACTIVE)
    else $error("collision not acted on");
  a_link_down: assert property (LINK_N [*8] |-> LINK_DOWN)
    else $error("link loss not shown");
  a_link_up: assert property (!LINK_N [*8] |-> !LINK_DOWN)
    else $error("link up not shown");
  a_carrier_high: assert property (RX_DV [*8] ##0 st_rd |-> PRDATA[1])
    else $error("carrier not reported");
  a_strap_status: assert property (st_rd |-> PRDATA[3:2] == {!SERIAL_SELECT_N, !DUPLEX_SELECT_N})
    else $error("strap status wrong");
endmodule

bind mii_phy_side_if mii_props i_mii_props (
  .REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .TX_CLK, .TXD,
  .TRANSMIT_FRAME_ACTIVE, .RX_DV, .COL, .LINK_N, .SERIAL_SELECT_N, .DUPLEX_SELECT_N, .LINK_DOWN
);

/* File: bench/tb_mii_phy_side_interface.sv */
// Self-checking bench for the MII end with its PHY model.
// Assumes the checker is bound through its own file.
module tb_mii_phy_side_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        serial_n = 1'b1;
  logic        duplex_n = 1'b1;
  logic [31:0] prdata, rdata;
  logic [3:0]  txd, rxd;
  logic        pready, pslverr, rerr, tfa, tx_clk, rx_clk, rx_dv, col, link_n, link_down;
  int          err_total = 0;
  int          check_count = 0;
  always #2 ref_clk = ~ref_clk;
  mii_phy_side_if i_mii_phy_side_if (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_CLK(tx_clk), .TXD(txd),
    .TRANSMIT_FRAME_ACTIVE(tfa), .RX_CLK(rx_clk), .RXD(rxd), .RX_DV(rx_dv), .COL(col), .LINK_N(link_n),
    .SERIAL_SELECT_N(serial_n), .DUPLEX_SELECT_N(duplex_n), .LINK_DOWN(link_down));
  mii_phy_model i_mii_phy_model (.tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv),
    .col(col), .link_n(link_n), .txd(txd), .tx_active(tfa));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, mii_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (rdata[b] !== v && n < 500);
    if (rdata[b] !== v) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic do_reset(input logic s, input logic d);
    rst <= 1'b1;
    serial_n <= s;
    duplex_n <= d;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 8'h10, 32'h0);
    chk({rdata[31:1], rerr}, 32'h1);
    apb(1'b0, mii_pkg::CTRL_OFS, 32'h0);
    chk(rdata, 32'(mii_pkg::CTRL_RESET));
    apb(1'b0, mii_pkg::STATUS_OFS, 32'h0);
    chk(rdata, {28'h0, !serial_n, !duplex_n, 2'h1});
    $display("test regs done");
  endtask
  task automatic t_link();
    i_mii_phy_model.link_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(32'(link_down), 32'h1);
    i_mii_phy_model.link_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(32'(link_down), 32'h0);
    $display("test link done");
  endtask
  task automatic t_tx();
    logic [3:0] exp[$];
    logic [7:0] b;
    i_mii_phy_model.tx_q.delete();
    apb(1'b1, mii_pkg::TXDATA_OFS, 32'h0a5);
    apb(1'b1, mii_pkg::CTRL_OFS, 32'h3);
    wait_st(mii_pkg::ST_TX_FULL_BIT, 1'b0);
    apb(1'b1, mii_pkg::TXDATA_OFS, 32'h13c);
    wait_st(mii_pkg::ST_TX_DONE_BIT, 1'b1);
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'h3c : 8'ha5;
      for (int i = 0; i < (serial_n ? 2 : 8); i++)
        exp.push_back(serial_n ? b[4*i+:4] : {3'h0, b[i]});
    end
    chk(32'(i_mii_phy_model.tx_q.size()), 32'(exp.size()));
    foreach (exp[i])
      chk(32'(i_mii_phy_model.tx_q[i]), 32'(exp[i]));
    apb(1'b1, mii_pkg::STATUS_OFS, 32'h200);
    apb(1'b0, mii_pkg::STATUS_OFS, 32'h0);
    chk(rdata & 32'h230, 32'h0);
    $display("test transmit done");
  endtask
  task automatic t_rx();
    i_mii_phy_model.rx_q = '{8'h5a, 8'hc3};
    fork
      i_mii_phy_model.send_rx(!serial_n);
      begin
        repeat (40) @(posedge ref_clk);
        apb(1'b0, mii_pkg::STATUS_OFS, 32'h0);
        chk(32'(rdata[1]), 32'h1);
      end
    join
    repeat (20) @(posedge ref_clk);
    apb(1'b0, mii_pkg::STATUS_OFS, 32'h0);
    chk(rdata & 32'h182, 32'h180);
    apb(1'b0, mii_pkg::RXDATA_OFS, 32'h0);
    chk(rdata, 32'h1c3);
    apb(1'b0, mii_pkg::RXDATA_OFS, 32'h0);
    chk(32'(rdata[8]), 32'h0);
    apb(1'b1, mii_pkg::STATUS_OFS, 32'h180);
    $display("test receive done");
  endtask
  task automatic t_col();
    int n;
    i_mii_phy_model.tx_q.delete();
    apb(1'b1, mii_pkg::CTRL_OFS, 32'h3);
    apb(1'b1, mii_pkg::TXDATA_OFS, 32'h0ff);
    n = 0;
    while (tfa !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'(tfa), 32'h1);
    if (tfa !== 1'b1)
      give_verdict();
    @(posedge tx_clk);
    @(posedge ref_clk);
    i_mii_phy_model.col <= 1'b1;
    repeat (10) @(posedge ref_clk);
    i_mii_phy_model.col <= 1'b0;
    wait_st(mii_pkg::ST_TX_BUSY_BIT, 1'b0);
    chk(32'(rdata[6]), 32'(duplex_n));
    if (!duplex_n)
      chk(32'(i_mii_phy_model.tx_q.size()), 32'h2);
    apb(1'b1, mii_pkg::STATUS_OFS, 32'h3c0);
    $display("test collision done");
  endtask
  ////////////////////////////////////////
  initial begin
    do_reset(1'b1, 1'b1);
    t_regs();
    t_link();
    t_tx();
    t_rx();
    t_col();
    do_reset(1'b0, 1'b1);
    t_regs();
    t_tx();
    t_rx();
    do_reset(1'b1, 1'b0);
    t_regs();
    t_col();
    give_verdict();
  end
endmodule

/* File: rtl/mii_phy_side_if.sv */
// MAC-side MII end with APB register access.
// Assumes a PHY sourcing both link clocks, far slower than REF_CLK.
//
// The placing of the registers and the APB register port are this design's own decisions.
module mii_phy_side_if (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // MII transmit
  input  wire logic        TX_CLK,
  output logic      [3:0]  TXD,
  output logic             TRANSMIT_FRAME_ACTIVE,
  // MII receive
  input  wire logic        RX_CLK,
  input  wire logic [3:0]  RXD,
  input  wire logic        RX_DV,
  input  wire logic        COL,
  // Link and straps
  input  wire logic        LINK_N,
  input  wire logic        SERIAL_SELECT_N,
  input  wire logic        DUPLEX_SELECT_N,
  output logic             LINK_DOWN
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  mii_pkg::mii_pins_t pins_raw;
  mii_pkg::mii_pins_t pins;
  logic [$bits(mii_pkg::mii_pins_t)-1:0] pins_q;

  always_comb begin
    pins_raw.tx_clk   = TX_CLK;
    pins_raw.rx_clk   = RX_CLK;
    pins_raw.rxd      = RXD;
    pins_raw.rxdv     = RX_DV;
    pins_raw.col      = COL;
    pins_raw.link_n   = LINK_N;
    pins_raw.serial_n = SERIAL_SELECT_N;
    pins_raw.duplex_n = DUPLEX_SELECT_N;
  end

  mii_sync #(.W($bits(mii_pkg::mii_pins_t))) i_mii_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   (pins_raw),
    .q   (pins_q)
  );
  assign pins = mii_pkg::mii_pins_t'(pins_q);

  logic tx_clk_prev_r;
  logic rx_clk_prev_r;
  logic tx_fall;
  logic rx_rise;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_clk_prev_r <= 1'b0;
      rx_clk_prev_r <= 1'b0;
    end else begin
      tx_clk_prev_r <= pins.tx_clk;
      rx_clk_prev_r <= pins.rx_clk;
    end
  end
  assign tx_fall = tx_clk_prev_r & ~pins.tx_clk;
  assign rx_rise = ~rx_clk_prev_r & pins.rx_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Straps caught after reset release
  logic [2:0] settle_r;
  logic       serial_mode_r;
  logic       full_duplex_r;
  logic [2:0] last_idx;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      settle_r      <= 3'h0;
      serial_mode_r <= 1'b0;
      full_duplex_r <= 1'b0;
    end else if (settle_r != mii_pkg::STRAP_SETTLE) begin
      settle_r      <= settle_r + 3'h1;
      serial_mode_r <= ~pins.serial_n;
      full_duplex_r <= ~pins.duplex_n;
    end
  end
  assign last_idx = serial_mode_r ? mii_pkg::SERIAL_LAST_IDX : mii_pkg::NIBBLE_LAST_IDX;

  ////////////////////////////////////////////////////////////////////////////
  // Link down flag
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LINK_DOWN <= 1'b1;
    end else begin
      LINK_DOWN <= pins.link_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode
  logic        acc;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_tx;
  logic        rd_rx;
  logic [1:0]  ctrl_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign acc       = PSEL & PENABLE & PREADY;
  assign wr_ctrl   = acc & PWRITE & hit(PADDR, mii_pkg::CTRL_OFS);
  assign wr_status = acc & PWRITE & hit(PADDR, mii_pkg::STATUS_OFS);
  assign wr_tx     = acc & PWRITE & hit(PADDR, mii_pkg::TXDATA_OFS);
  assign rd_rx     = acc & ~PWRITE & hit(PADDR, mii_pkg::RXDATA_OFS);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= mii_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= PWDATA[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit
  mii_pkg::mii_tx_state_t tx_state_r;
  logic [7:0] tx_hold_r;
  logic       tx_hold_last_r;
  logic       tx_pend_r;
  logic [7:0] tx_byte_r;
  logic       tx_byte_last_r;
  logic [2:0] tx_idx_r;
  logic       coll_hit;
  logic       coll_r;
  logic       tx_done_r;
  logic       tx_take;
  logic       tx_end;

  assign coll_hit = pins.col & ~full_duplex_r & (tx_state_r == mii_pkg::TX_SEND);

  function automatic logic [3:0] tx_unit(input logic [7:0] b, input logic [2:0] i, input logic ser);
    if (ser) begin
      tx_unit = {3'h0, b[i]};
    end else begin
      tx_unit = i[0] ? b[7:4] : b[3:0];
    end
  endfunction

  always_comb begin
    tx_take = 1'b0;
    tx_end  = 1'b0;
    if (tx_fall && !coll_hit) begin
      case (tx_state_r)
        mii_pkg::TX_IDLE: begin
          tx_take = tx_pend_r & ctrl_r[mii_pkg::CTRL_TX_EN_BIT];
        end
        mii_pkg::TX_SEND: begin
          if (tx_idx_r == last_idx) begin
            tx_take = tx_pend_r & ~tx_byte_last_r;
            tx_end  = ~tx_take;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_state_r            <= mii_pkg::TX_IDLE;
      tx_byte_r             <= 8'h00;
      tx_byte_last_r        <= 1'b0;
      tx_idx_r              <= 3'h0;
      TXD                   <= 4'h0;
      TRANSMIT_FRAME_ACTIVE <= 1'b0;
    end else if (coll_hit) begin
      tx_state_r            <= mii_pkg::TX_IDLE;
      TXD                   <= 4'h0;
      TRANSMIT_FRAME_ACTIVE <= 1'b0;
    end else if (tx_take) begin
      tx_state_r            <= mii_pkg::TX_SEND;
      tx_byte_r             <= tx_hold_r;
      tx_byte_last_r        <= tx_hold_last_r;
      tx_idx_r              <= 3'h0;
      TXD                   <= tx_unit(tx_hold_r, 3'h0, serial_mode_r);
      TRANSMIT_FRAME_ACTIVE <= 1'b1;
    end else if (tx_end) begin
      tx_state_r            <= mii_pkg::TX_IDLE;
      TXD                   <= 4'h0;
      TRANSMIT_FRAME_ACTIVE <= 1'b0;
    end else if (tx_fall && tx_state_r == mii_pkg::TX_SEND) begin
      tx_idx_r <= tx_idx_r + 3'h1;
      TXD      <= tx_unit(tx_byte_r, tx_idx_r + 3'h1, serial_mode_r);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_hold_r      <= 8'h00;
      tx_hold_last_r <= 1'b0;
      tx_pend_r      <= 1'b0;
    end else if (wr_tx && !tx_pend_r) begin
      tx_hold_r      <= PWDATA[7:0];
      tx_hold_last_r <= PWDATA[mii_pkg::DATA_LAST_BIT];
      tx_pend_r      <= 1'b1;
    end else if (tx_take || coll_hit) begin
      tx_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive
  logic [7:0] rx_asm_r;
  logic [7:0] rx_asm_nxt;
  logic [2:0] rx_idx_r;
  logic       rxdv_prev_r;
  logic [7:0] rx_data_r;
  logic       rx_valid_r;
  logic       rx_ovr_r;
  logic       rx_end_r;
  logic       rx_byte;
  logic       rx_frame_end;

  always_comb begin
    rx_asm_nxt = rx_asm_r;
    if (serial_mode_r) begin
      rx_asm_nxt[rx_idx_r] = pins.rxd[0];
    end else if (rx_idx_r[0]) begin
      rx_asm_nxt[7:4] = pins.rxd;
    end else begin
      rx_asm_nxt[3:0] = pins.rxd;
    end
  end

  assign rx_byte      = rx_rise & pins.rxdv & ctrl_r[mii_pkg::CTRL_RX_EN_BIT] & (rx_idx_r == last_idx);
  assign rx_frame_end = rx_rise & rxdv_prev_r & ~pins.rxdv;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rx_asm_r    <= 8'h00;
      rx_idx_r    <= 3'h0;
      rxdv_prev_r <= 1'b0;
      rx_data_r   <= 8'h00;
    end else if (rx_rise) begin
      rxdv_prev_r <= pins.rxdv;
      if (pins.rxdv && ctrl_r[mii_pkg::CTRL_RX_EN_BIT]) begin
        rx_asm_r <= rx_asm_nxt;
        rx_idx_r <= rx_byte ? 3'h0 : rx_idx_r + 3'h1;
        if (rx_byte) begin
          rx_data_r <= rx_asm_nxt;
        end
      end else begin
        rx_idx_r <= 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rx_valid_r <= 1'b0;
      rx_ovr_r   <= 1'b0;
      rx_end_r   <= 1'b0;
      coll_r     <= 1'b0;
      tx_done_r  <= 1'b0;
    end else begin
      rx_valid_r <= (rx_valid_r & ~rd_rx) | rx_byte;
      rx_ovr_r   <= (rx_ovr_r & ~(wr_status & PWDATA[mii_pkg::ST_RX_OVR_BIT])) | (rx_byte & rx_valid_r & ~rd_rx);
      rx_end_r   <= (rx_end_r & ~(wr_status & PWDATA[mii_pkg::ST_RX_END_BIT])) | rx_frame_end;
      coll_r     <= (coll_r & ~(wr_status & PWDATA[mii_pkg::ST_COLL_BIT])) | coll_hit;
      tx_done_r  <= (tx_done_r & ~(wr_status & PWDATA[mii_pkg::ST_TX_DONE_BIT])) | tx_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer
  logic [mii_pkg::ST_WIDTH-1:0] status;

  always_comb begin
    status                              = '0;
    status[mii_pkg::ST_LINK_UP_BIT]     = ~LINK_DOWN;
    status[mii_pkg::ST_CARRIER_BIT]     = pins.rxdv;
    status[mii_pkg::ST_FULL_DPX_BIT]    = full_duplex_r;
    status[mii_pkg::ST_SERIAL_BIT]      = serial_mode_r;
    status[mii_pkg::ST_TX_BUSY_BIT]     = TRANSMIT_FRAME_ACTIVE;
    status[mii_pkg::ST_TX_FULL_BIT]     = tx_pend_r;
    status[mii_pkg::ST_COLL_BIT]        = coll_r;
    status[mii_pkg::ST_RX_OVR_BIT]      = rx_ovr_r;
    status[mii_pkg::ST_RX_END_BIT]      = rx_end_r;
    status[mii_pkg::ST_TX_DONE_BIT]     = tx_done_r;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && !PENABLE) begin
        if (hit(PADDR, mii_pkg::CTRL_OFS)) begin
          PRDATA <= {30'h0, ctrl_r};
        end else if (hit(PADDR, mii_pkg::STATUS_OFS)) begin
          PRDATA <= {22'h0, status};
        end else if (hit(PADDR, mii_pkg::TXDATA_OFS)) begin
          PRDATA <= {23'h0, tx_hold_last_r, tx_hold_r};
        end else if (hit(PADDR, mii_pkg::RXDATA_OFS)) begin
          PRDATA <= {23'h0, rx_valid_r, rx_data_r};
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: rtl/mii_pkg.sv */
// Constants, register map and types for the MII PHY-side interface.
// Assumes one 250 MHz core clock with APB access; all MII pins arrive asynchronously.
package mii_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0c;

  // Control fields
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_TX_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status fields
  localparam int ST_LINK_UP_BIT  = 0;
  localparam int ST_CARRIER_BIT  = 1;
  localparam int ST_FULL_DPX_BIT = 2;
  localparam int ST_SERIAL_BIT   = 3;
  localparam int ST_TX_BUSY_BIT  = 4;
  localparam int ST_TX_FULL_BIT  = 5;
  localparam int ST_COLL_BIT     = 6;
  localparam int ST_RX_OVR_BIT   = 7;
  localparam int ST_RX_END_BIT   = 8;
  localparam int ST_TX_DONE_BIT  = 9;
  localparam int ST_WIDTH        = 10;

  // Data register fields
  localparam int DATA_LAST_BIT  = 8;
  localparam int DATA_VALID_BIT = 8;

  // Last unit index per byte
  localparam logic [2:0] NIBBLE_LAST_IDX = 3'h1;
  localparam logic [2:0] SERIAL_LAST_IDX = 3'h7;

  // Core clock and strap settle time
  localparam int         REF_CLK_PERIOD_NS = 4;
  localparam logic [2:0] STRAP_SETTLE      = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Pin bundle seen through the synchroniser
  typedef struct packed {
    logic       tx_clk;
    logic       rx_clk;
    logic [3:0] rxd;
    logic       rxdv;
    logic       col;
    logic       link_n;
    logic       serial_n;
    logic       duplex_n;
  } mii_pins_t;

  typedef enum logic {TX_IDLE, TX_SEND} mii_tx_state_t;

endpackage

/* File: rtl/mii_sync.sv */
// Three-stage synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output follows once stages two and three agree.
module mii_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          q[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  endgenerate

endmodule
